/* File: tos_defs.svh */
// Purpose: constants for the thermal overload stage
// Assumes: fixed-point per-unit values, Q8.8 unless noted
// Notes:   APB byte offsets, field positions, reset values, timing
`ifndef TOS_DEFS_SVH
`define TOS_DEFS_SVH

// Register byte offsets
`define TOS_OFS_CTRL      12'h000
`define TOS_OFS_KFACT     12'h004
`define TOS_OFS_ALARM     12'h008
`define TOS_OFS_TAU       12'h00c
`define TOS_OFS_CTAU      12'h010
`define TOS_OFS_LOAD40    12'h014
`define TOS_OFS_LOAD70    12'h018
`define TOS_OFS_TAMB      12'h01c
`define TOS_OFS_THETA     12'h020
`define TOS_OFS_IMAXRMS   12'h024
`define TOS_OFS_STATUS    12'h028
`define TOS_OFS_IRQ_STAT  12'h02c
`define TOS_OFS_IRQ_MASK  12'h030
`define TOS_OFS_KAMB      12'h034

// Control register fields
`define TOS_CTRL_SENSOR   0
`define TOS_CTRL_FORCE    1
`define TOS_CTRL_FTRIP    2
`define TOS_CTRL_FSTART   3

// Status / interrupt fields
`define TOS_ST_TRIP       0
`define TOS_ST_START      1
`define TOS_ST_COOL       2
`define TOS_ST_FORCE      3
`define TOS_IRQ_W         4

// Per-unit constants, Q8.8 (256 = 1.0); ambient in whole degrees, tau in minutes, harmonic order plain
`define TOS_PU_ONE        16'h0100
`define TOS_THETA_INIT    16'h00b3
`define TOS_THETA_TRIP    16'h0100
`define TOS_COOL_LIMIT    16'h004d
`define TOS_HYST          16'h0005
`define TOS_KFACT_RST     16'h010f
`define TOS_ALARM_RST     16'h00cc
`define TOS_CTAU_RST      16'h0100
`define TOS_LOAD40_RST    16'h0100
`define TOS_LOAD70_RST    16'h00c0
`define TOS_TAMB_RST      16'sh0028
`define TOS_TAMB_LO       16'sh0028
`define TOS_TAMB_SPAN     16'sh001e
`define TOS_TAU_RST       16'h001e
`define TOS_HARM_MAX      15

// Timing
`define TOS_CLK_HZ        200000000
`define TOS_FORCE_S       300
`define TOS_SAMPLE_MS     100
`define TOS_FORCE_CYC     (`TOS_FORCE_S * 64'(`TOS_CLK_HZ))
`define TOS_SAMP_PER_MIN  (60000 / `TOS_SAMPLE_MS)
`define TOS_SAMPLE_CYC    (`TOS_SAMPLE_MS * (`TOS_CLK_HZ / 1000))

`endif

/* File: tos_pkg.sv */
// Purpose: types for the thermal overload stage
// Assumes: tos_defs.svh holds the numbers
// Notes:   carriers only
package tos_pkg;
    typedef struct packed {
        logic [15:0] l1;
        logic [15:0] l2;
        logic [15:0] l3;
    } tos_phase_t;

    typedef struct packed {
        logic trip;
        logic start;
    } tos_out_t;

    typedef enum logic [2:0] {
        TOS_IDLE  = 3'b001,
        TOS_CALC  = 3'b010,
        TOS_STORE = 3'b100
    } tos_state_t;
endpackage

/* File: tos_amb.sv */
// Purpose: ambient correction factor for the overload stage
// Assumes: allowed loads Q8.8, ambient in whole degrees signed
// Notes:   linear between +40 and +70, held flat outside
`timescale 1ns/1ps
`include "tos_defs.svh"
module tos_amb (
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire logic               sensor_en,
    input  wire logic        [15:0] allowed_load_at_40c,
    input  wire logic        [15:0] allowed_load_at_70c,
    input  wire logic signed [15:0] tamb,
    output logic             [15:0] kamb
);
    logic signed [15:0] dt;
    logic signed [17:0] slope;
    logic signed [33:0] prod;
    logic        [15:0] kamb_nxt;

    // Interpolation over the 30 degree span
    always_comb begin
        dt = tamb - `TOS_TAMB_LO;
        if (dt < 16'sh0000)
            dt = 16'sh0000;
        if (dt > `TOS_TAMB_SPAN)
            dt = `TOS_TAMB_SPAN;
        slope = $signed({2'b00, allowed_load_at_70c})
              - $signed({2'b00, allowed_load_at_40c});
        prod = slope * dt;
        kamb_nxt = 16'(($signed({2'b00, allowed_load_at_40c, 16'h0000})
                   + ((prod <<< 16) / `TOS_TAMB_SPAN)) >>> 16);
        // Correction off: unity load at 40 or no sensor
        if (!sensor_en || allowed_load_at_40c == `TOS_PU_ONE)
            kamb_nxt = `TOS_PU_ONE;
    end

    // Registered factor
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            kamb <= `TOS_PU_ONE;
        else
            kamb <= kamb_nxt;
    end
endmodule

/* File: tos_stage.sv */
// Purpose: thermal overload stage with APB settings and status
// Assumes: rms phase currents per unit of rated current, Q8.8
// Notes:   theta is rise in Q8.8; model steps once per sample tick
`timescale 1ns/1ps
`include "tos_defs.svh"
// Summary of operation
// - Phase rms inputs carry harmonics up to the fifteenth.
// - Model current is the largest of the three phase currents.
// - Temperature rise held as state; preload equals sqrt(rise)*k*kamb*In.
// - Heating follows tau toward (I/a) squared, trip time by log law.
// - Cooling uses tau times the cooling coefficient.
// - Cooling coefficient applies below 0.3 times rated current.
// - Trip when rise reaches 100 percent of k*kamb*In.
// - Ambient factor from ambient and the 40/70 degree loads.
// - Ambient factor is one at unity 40 degree load or no sensor.
// - Rise starts at 70 percent after power-up.
// - Force flag clears itself five minutes after being set.
// - Start output asserts when rise reaches the alarm level.
module tos_stage #(
    parameter logic [63:0] FORCE_CYC  = `TOS_FORCE_CYC,
    parameter int          SAMPLE_CYC = `TOS_SAMPLE_CYC
) (
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire tos_pkg::tos_phase_t irms,
    input  wire logic               irms_valid,
    input  wire logic        [11:0] paddr,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic        [31:0] pwdata,
    output logic             [31:0] prdata,
    output logic                    pready,
    output logic                    pslverr,
    output tos_pkg::tos_out_t       stage_out,
    output logic                    irq
);
    // Settings
    logic [15:0] kfact_r, alarm_r, tau_r, ctau_r, load40_r, load70_r;
    logic signed [15:0] tamb_r;
    logic        sensor_r, force_r, ftrip_r, fstart_r;
    logic [63:0] force_cnt_r;
    // Model state
    logic [15:0] theta_r, imax_r, kamb;
    logic        cool_r;
    tos_pkg::tos_state_t state_r;
    logic [31:0] tick_cnt_r;
    logic        tick;
    logic [31:0] a2_r, target_r;
    logic        trip_r, start_r;
    logic [`TOS_IRQ_W-1:0] irq_stat_r, irq_mask_r, ev;
    logic        wr_en, rd_en, hit;
    logic [31:0] rd_nxt;

    tos_amb u_amb (
        .clk                 (clk),
        .rst_n               (rst_n),
        .sensor_en           (sensor_r),
        .allowed_load_at_40c (load40_r),
        .allowed_load_at_70c (load70_r),
        .tamb                (tamb_r),
        .kamb                (kamb)
    );

    // Writes and read side effects land on the pready edge only
    assign wr_en = psel && penable && pwrite && pready;
    assign rd_en = psel && penable && !pwrite && pready;

    // Setting registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            kfact_r  <= `TOS_KFACT_RST;
            alarm_r  <= `TOS_ALARM_RST;
            tau_r    <= `TOS_TAU_RST;
            ctau_r   <= `TOS_CTAU_RST;
            load40_r <= `TOS_LOAD40_RST;
            load70_r <= `TOS_LOAD70_RST;
            tamb_r   <= `TOS_TAMB_RST;
            sensor_r <= 1'b0;
            ftrip_r  <= 1'b0;
            fstart_r <= 1'b0;
        end else if (wr_en) begin
            unique case (paddr)
                `TOS_OFS_CTRL: begin
                    sensor_r <= pwdata[`TOS_CTRL_SENSOR];
                    ftrip_r  <= pwdata[`TOS_CTRL_FTRIP];
                    fstart_r <= pwdata[`TOS_CTRL_FSTART];
                end
                `TOS_OFS_KFACT:  kfact_r  <= pwdata[15:0];
                `TOS_OFS_ALARM:  alarm_r  <= pwdata[15:0];
                `TOS_OFS_TAU:    tau_r    <= pwdata[15:0];
                `TOS_OFS_CTAU:   ctau_r   <= pwdata[15:0];
                `TOS_OFS_LOAD40: load40_r <= pwdata[15:0];
                `TOS_OFS_LOAD70: load70_r <= pwdata[15:0];
                `TOS_OFS_TAMB:   tamb_r   <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    // Force flag with self-clearing timeout
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            force_r     <= 1'b0;
            force_cnt_r <= 64'h0;
        end else if (wr_en && paddr == `TOS_OFS_CTRL) begin
            force_r     <= pwdata[`TOS_CTRL_FORCE];
            force_cnt_r <= 64'h0;
        end else if (force_r) begin
            if (force_cnt_r >= FORCE_CYC - 64'h1) begin
                force_r     <= 1'b0;
                force_cnt_r <= 64'h0;
            end else begin
                force_cnt_r <= force_cnt_r + 64'h1;
            end
        end
    end

    // Sample tick divider
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_r <= 32'h0;
            tick       <= 1'b0;
        end else if (tick_cnt_r >= 32'(SAMPLE_CYC - 1)) begin
            tick_cnt_r <= 32'h0;
            tick       <= 1'b1;
        end else begin
            tick_cnt_r <= tick_cnt_r + 32'h1;
            tick       <= 1'b0;
        end
    end

    // Highest phase; inputs already hold harmonics to 15th
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            imax_r <= 16'h0;
            cool_r <= 1'b0;
        end else if (irms_valid) begin
            if (irms.l1 >= irms.l2 && irms.l1 >= irms.l3)
                imax_r <= irms.l1;
            else if (irms.l2 >= irms.l3)
                imax_r <= irms.l2;
            else
                imax_r <= irms.l3;
        end else begin
            cool_r <= imax_r < `TOS_COOL_LIMIT;
        end
    end

    // Model sequencer: a squared, then target, then step
    logic [31:0] ka, i2, eff_tau, tgt_nxt, tau_min;
    logic [47:0] tau_x;
    always_comb begin
        ka      = 32'(kfact_r) * 32'(kamb);       // Q16.16, a = k*kamb*In
        i2      = 32'(imax_r) * 32'(imax_r);      // Q16.16
        tau_x   = 48'(tau_r) * 48'(ctau_r);
        // Cooling tau stretched by the coefficient
        tau_min = cool_r ? 32'(tau_x >> 8) : 32'(tau_r);
        // Samples per tau, 600 samples per minute at 100 ms
        eff_tau = tau_min * 32'(`TOS_SAMP_PER_MIN);
        if (eff_tau == 32'h0)
            eff_tau = 32'h1;
        // Steady rise = (I/a)^2 in Q8.8
        tgt_nxt = (a2_r == 32'h0) ? 32'h0000ffff
                : 32'((64'(i2) << 8) / 64'(a2_r));
        if (tgt_nxt > 32'h0000ffff)
            tgt_nxt = 32'h0000ffff;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r  <= tos_pkg::TOS_IDLE;
            a2_r     <= 32'h0;
            target_r <= 32'h0;
            theta_r  <= `TOS_THETA_INIT;
        end else begin
            unique case (state_r)
                tos_pkg::TOS_IDLE: begin
                    if (tick) begin
                        // Square is Q32.32; back to Q16.16 like i2
                        a2_r    <= 32'((64'(ka) * 64'(ka)) >> 16);
                        state_r <= tos_pkg::TOS_CALC;
                    end
                end
                tos_pkg::TOS_CALC: begin
                    target_r <= tgt_nxt;
                    state_r  <= tos_pkg::TOS_STORE;
                end
                tos_pkg::TOS_STORE: begin
                    // First-order step theta += (target-theta)/Nsamp
                    if (target_r >= 32'(theta_r))
                        theta_r <= 16'(32'(theta_r)
                            + (target_r - 32'(theta_r) + eff_tau - 32'h1)
                            / eff_tau);
                    else
                        theta_r <= 16'(32'(theta_r)
                            - (32'(theta_r) - target_r + eff_tau - 32'h1)
                            / eff_tau);
                    state_r <= tos_pkg::TOS_IDLE;
                end
                default: state_r <= tos_pkg::TOS_IDLE;
            endcase
        end
    end

    // Trip and start with release hysteresis, force override
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            trip_r  <= 1'b0;
            start_r <= 1'b0;
        end else begin
            if (theta_r >= `TOS_THETA_TRIP)
                trip_r <= 1'b1;
            else if (theta_r + `TOS_HYST < `TOS_THETA_TRIP)
                trip_r <= 1'b0;
            if (theta_r >= alarm_r)
                start_r <= 1'b1;
            else if (theta_r + `TOS_HYST < alarm_r)
                start_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            stage_out <= '0;
        else begin
            stage_out.trip  <= trip_r  | (force_r & ftrip_r);
            stage_out.start <= start_r | (force_r & fstart_r);
        end
    end

    // Interrupt events: trip rise, start rise, cooling entry, force expiry
    assign ev[`TOS_ST_TRIP]  = (theta_r >= `TOS_THETA_TRIP) && !trip_r;
    assign ev[`TOS_ST_START] = (theta_r >= alarm_r) && !start_r;
    assign ev[`TOS_ST_COOL]  = !cool_r && irms_valid == 1'b0
                               && imax_r < `TOS_COOL_LIMIT;
    assign ev[`TOS_ST_FORCE] = force_r && force_cnt_r >= FORCE_CYC - 64'h1;

    // Sticky status; a read clears only the bits it reported
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat_r <= '0;
            irq_mask_r <= '0;
        end else begin
            if (rd_en && paddr == `TOS_OFS_IRQ_STAT)
                irq_stat_r <= (irq_stat_r & ~prdata[`TOS_IRQ_W-1:0]) | ev;
            else
                irq_stat_r <= irq_stat_r | ev;
            if (wr_en && paddr == `TOS_OFS_IRQ_MASK)
                irq_mask_r <= pwdata[`TOS_IRQ_W-1:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            irq <= 1'b0;
        else
            irq <= |((irq_stat_r | ev) & irq_mask_r);
    end

    // Read mux
    always_comb begin
        hit    = 1'b1;
        rd_nxt = 32'h0;
        unique case (paddr)
            `TOS_OFS_CTRL: rd_nxt = 32'({fstart_r, ftrip_r, force_r,
                                          sensor_r});
            `TOS_OFS_KFACT:    rd_nxt = 32'(kfact_r);
            `TOS_OFS_ALARM:    rd_nxt = 32'(alarm_r);
            `TOS_OFS_TAU:      rd_nxt = 32'(tau_r);
            `TOS_OFS_CTAU:     rd_nxt = 32'(ctau_r);
            `TOS_OFS_LOAD40:   rd_nxt = 32'(load40_r);
            `TOS_OFS_LOAD70:   rd_nxt = 32'(load70_r);
            `TOS_OFS_TAMB:     rd_nxt = 32'(tamb_r);
            `TOS_OFS_THETA:    rd_nxt = 32'(theta_r);
            `TOS_OFS_IMAXRMS:  rd_nxt = 32'(imax_r);
            `TOS_OFS_STATUS:   rd_nxt = 32'({force_r, cool_r, start_r,
                                              trip_r});
            `TOS_OFS_IRQ_STAT: rd_nxt = 32'(irq_stat_r);
            `TOS_OFS_IRQ_MASK: rd_nxt = 32'(irq_mask_r);
            `TOS_OFS_KAMB:     rd_nxt = 32'(kamb);
            default:           hit    = 1'b0;
        endcase
    end

    // APB answer: one wait state, data and error from flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else if (psel && penable && !pready) begin
            pready  <= 1'b1;
            pslverr <= !hit;
            prdata  <= pwrite ? 32'h0 : rd_nxt;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end
endmodule

/* File: tos_stage_props.sv */
// Purpose: port-level assertions for the overload stage
// Assumes: APB master holds each request until pready
// Notes:   bound to every tos_stage instance below
`timescale 1ns/1ps
module tos_stage_chk #(
    parameter logic [63:0] FORCE_CYC  = 64'd50,
    parameter int          SAMPLE_CYC = 10
) (
    input wire logic              clk,
    input wire logic              rst_n,
    input wire logic       [11:0] paddr,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic       [31:0] prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire tos_pkg::tos_out_t stage_out,
    input wire logic              irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Access phase still waiting, then a one-cycle answer
    sequence s_access;
        psel && penable && !pready;
    endsequence
    sequence s_answer;
        pready ##1 !pready;
    endsequence
    AST_READY_NEXT: assert property (s_access |=> s_answer)
        else $error("pready late or longer than one cycle");
    AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
        else $error("pready outside an access phase");
    AST_NO_READY_IDLE: assert property (!psel |=> !pready)
        else $error("pready without a selected transfer");
    AST_ERR_WITH_READY: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    AST_ERR_UNMAPPED: assert property (pready && paddr > 12'h034 |-> pslverr)
        else $error("unmapped address answered without error");
    AST_OK_MAPPED: assert property (
        pready && paddr <= 12'h034 && paddr[1:0] == 2'b00 |-> !pslverr)
        else $error("mapped register answered with error");
    AST_ERR_READ_ZERO: assert property (
        pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
        else $error("refused read returned nonzero data");
    // Registered outputs come out of reset quiet
    AST_RESET_QUIET: assert property ($rose(rst_n) |->
        !stage_out.trip && !stage_out.start && !irq && !pready)
        else $error("outputs active right after reset");
endmodule

bind tos_stage tos_stage_chk #(
    .FORCE_CYC (FORCE_CYC),
    .SAMPLE_CYC(SAMPLE_CYC)
) u_chk (.clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .stage_out(stage_out), .irq(irq));

/* File: tos_front.sv */
// Purpose: phase current front end model feeding rms values
// Assumes: bench sets the rms level of each phase
// Notes:   data is shown inverted between frames, never stale
`timescale 1ns/1ps
module tos_front (
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire tos_pkg::tos_phase_t level,
    output tos_pkg::tos_phase_t      irms,
    output logic                     irms_valid
);
    logic [1:0] ph_r;
    // One rms result per four cycles; junk in between
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ph_r       <= 2'h0;
            irms_valid <= 1'b0;
            irms       <= '0;
        end else begin
            ph_r       <= ph_r + 2'h1;
            irms_valid <= (ph_r == 2'h3);
            irms       <= (ph_r == 2'h3) ? level : ~level;
        end
    end
endmodule

/* File: tos_tb.sv */
// Purpose: self-checking bench for the overload stage
// Assumes: short sample and force counts for a quick run
// Notes:   table of register reads first, hand tests after
`timescale 1ns/1ps
`include "tos_defs.svh"
module testbench;
    typedef struct packed {
        logic [11:0] addr;
        logic [47:0] cur;
        logic [31:0] exp;
    } tos_row_t;
    logic                clk = 1'b0;
    logic                rst_n, psel, penable, pwrite, pready, pslverr;
    logic                irq, irms_valid, er;
    logic         [11:0] paddr;
    logic         [31:0] pwdata, prdata, rd;
    tos_pkg::tos_phase_t level, irms;
    tos_pkg::tos_out_t   stage_out;
    int                  err_count, comparisons, cycles, n1, n2;
    tos_row_t            rows [13];
    logic         [15:0] amb [3], l40 [3], kx [3];

    tos_front fe (.clk(clk), .rst_n(rst_n), .level(level), .irms(irms),
        .irms_valid(irms_valid));
    tos_stage #(.FORCE_CYC(64'd50), .SAMPLE_CYC(10)) dut (.clk(clk),
        .rst_n(rst_n), .irms(irms), .irms_valid(irms_valid), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .stage_out(stage_out), .irq(irq));

    always #2.5 clk = ~clk;
    // Hang guard, far above the expected run length
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            err_count++;
            stop_test();
        end
    end

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got,
                       input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One APB transfer; idle cycle first so signals never change twice
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= d;
        psel    <= 1'b1;
        penable <= 1'b0;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    // Bounded wait for one output bit (1 trip, 0 start) to reach v
    task automatic wait_out(input int b, input logic v, output int n);
        n = 0;
        while (stage_out[b] !== v && n < 20000) begin
            @(posedge clk);
            n++;
        end
    endtask

    initial begin
        rows = '{'{`TOS_OFS_THETA, 48'h0, 32'hb3},
            '{`TOS_OFS_KFACT, 48'h0, 32'h10f}, '{`TOS_OFS_ALARM, 48'h0, 32'hcc},
            '{`TOS_OFS_TAU, 48'h0, 32'h1e}, '{`TOS_OFS_CTAU, 48'h0, 32'h100},
            '{`TOS_OFS_LOAD40, 48'h0, 32'h100}, '{`TOS_OFS_LOAD70, 48'h0, 32'hc0},
            '{`TOS_OFS_TAMB, 48'h0, 32'h28}, '{`TOS_OFS_KAMB, 48'h0, 32'h100},
            '{`TOS_OFS_IMAXRMS, 48'h0080_0040_0020, 32'h80},
            '{`TOS_OFS_IMAXRMS, 48'h0010_01a0_0030, 32'h1a0},
            '{`TOS_OFS_IMAXRMS, 48'h0000_0000_0120, 32'h120},
            '{`TOS_OFS_IMAXRMS, 48'h004c_004c_004c, 32'h4c}};
        amb = '{16'h0028, 16'h0046, 16'h0046};
        l40 = '{16'h00e0, 16'h00e0, 16'h0100};
        kx  = '{16'h00e0, 16'h00c0, 16'h0100};
        {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        level = '0;
        {err_count, comparisons, cycles} = '0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        // Reset values, then largest phase as model current
        foreach (rows[i]) begin
            level <= rows[i].cur;
            if (i > 8) repeat (8) @(posedge clk);
            apb(1'b0, rows[i].addr, 32'h0);
            chk("table", rd, rows[i].exp);
        end
        $display("table done");
        apb(1'b0, 12'h100, 32'h0);
        chk("unmapped err", 32'(er), 32'h1);
        chk("unmapped data", rd, 32'h0);
        $display("refusal done");
        // Ambient factor across the 40 and 70 degree points
        apb(1'b1, `TOS_OFS_CTRL, 32'h1);
        apb(1'b1, `TOS_OFS_LOAD70, 32'hc0);
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, `TOS_OFS_TAMB, 32'(amb[i]));
            apb(1'b1, `TOS_OFS_LOAD40, 32'(l40[i]));
            repeat (4) @(posedge clk);
            apb(1'b0, `TOS_OFS_KAMB, 32'h0);
            chk("kamb", rd, 32'(kx[i]));
        end
        apb(1'b1, `TOS_OFS_CTRL, 32'h0);
        $display("ambient done");
        // Overload of 2.0 against k 1.0: start, trip, then cool
        apb(1'b1, `TOS_OFS_KFACT, 32'h100);
        apb(1'b1, `TOS_OFS_TAU, 32'h1);
        apb(1'b1, `TOS_OFS_IRQ_MASK, 32'hf);
        apb(1'b0, `TOS_OFS_IRQ_STAT, 32'h0);
        level <= 48'h0200_0200_0200;
        wait_out(0, 1'b1, n1);
        wait_out(1, 1'b1, n2);
        chk("start", 32'(stage_out.start), 32'h1);
        chk("trip time", 32'(n1 + n2 > 200 && n1 + n2 < 3000), 32'h1);
        chk("irq on", 32'(irq), 32'h1);
        apb(1'b0, `TOS_OFS_STATUS, 32'h0);
        chk("status", rd & 32'h3, 32'h3);
        apb(1'b0, `TOS_OFS_IRQ_STAT, 32'h0);
        chk("events", rd & 32'h3, 32'h3);
        repeat (2) @(posedge clk);
        chk("irq off", 32'(irq), 32'h0);
        level <= 48'h0;
        wait_out(1, 1'b0, n1);
        apb(1'b0, `TOS_OFS_STATUS, 32'h0);
        chk("cool", rd & 32'h5, 32'h4);
        chk("irq cool", 32'(irq), 32'h1);
        wait_out(0, 1'b0, n1);
        chk("start drop", 32'(n1 < 20000), 32'h1);
        $display("thermal done");
        // Forced trip and its self-clearing flag
        apb(1'b1, `TOS_OFS_IRQ_MASK, 32'h0);
        apb(1'b0, `TOS_OFS_IRQ_STAT, 32'h0);
        apb(1'b1, `TOS_OFS_CTRL, 32'h6);
        repeat (2) @(posedge clk);
        chk("forced trip", 32'(stage_out.trip), 32'h1);
        apb(1'b0, `TOS_OFS_STATUS, 32'h0);
        chk("force set", rd & 32'h8, 32'h8);
        repeat (60) @(posedge clk);
        apb(1'b0, `TOS_OFS_STATUS, 32'h0);
        chk("force gone", rd & 32'h9, 32'h0);
        apb(1'b0, `TOS_OFS_IRQ_STAT, 32'h0);
        chk("force event", rd & 32'h8, 32'h8);
        chk("irq masked", 32'(irq), 32'h0);
        $display("force done");
        // Reset in mid-run restarts the model at 70 percent
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        chk("reset outs", 32'({stage_out, irq}), 32'h0);
        rst_n <= 1'b1;
        apb(1'b0, `TOS_OFS_THETA, 32'h0);
        chk("theta restart", rd, 32'hb3);
        $display("reset done");
        stop_test();
    end
endmodule
